// File: common/lsd_regs.vh
// Functional notes
// - two channels, each a 20-stage two-way shift register and 20-bit latch
// - ch1 direction high: input on right pin, output on left; low swaps
// - ch2 direction selects ch2 left and right pins the same way
// - segment mode: shift on second strobe fall, latch on first strobe fall
// - segment mode: ch2 uses the same strobe assignment as ch1
// - common mode: ch2 shifts on first strobe rise, latches on second rise
// - common mode: ch2 uses inverted alternation; ch1 never inverts it
// - ch1 levels: 1/high A, 1/low B, 0/high C, 0/low D
// - ch2 segment levels: 1/high A, 1/low B, 0/high E, 0/low F
// - ch2 common levels: 1/high B, 1/low A, 0/high F, 0/low E
`ifndef LSD_REGS_VH
`define LSD_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSD_CTRL_OFS      8'h00
`define LSD_STAT_OFS      8'h04
`define LSD_LATCH1_OFS    8'h08
`define LSD_LATCH2_OFS    8'h0c
`define LSD_SNAP_LO_OFS   8'h10
`define LSD_SNAP_HI_OFS   8'h14

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define LSD_CTRL_DIR1_BIT 0
`define LSD_CTRL_DIR2_BIT 1
`define LSD_CTRL_FSEL_BIT 2
`define LSD_CTRL_RST      3'h0

// ----------------------------------------
// status fields
// ----------------------------------------
`define LSD_STAT_EMPTY_BIT 0
`define LSD_STAT_FULL_BIT  1
`define LSD_STAT_OVF_BIT   2
`define LSD_STAT_CNT_LSB   4

// ----------------------------------------
// drive level codes
// ----------------------------------------
`define LSD_LVL_A 3'h0
`define LSD_LVL_B 3'h1
`define LSD_LVL_C 3'h2
`define LSD_LVL_D 3'h3
`define LSD_LVL_E 3'h4
`define LSD_LVL_F 3'h5

// ----------------------------------------
// timing
// ----------------------------------------
`define LSD_SYNC_STAGES 2

`endif

// File: dv/lsd_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module lsd_checker #(
    parameter W = 20
) (
    input logic           clock_i,
    input logic           resetn_i,
    input logic           psel_i,
    input logic           penable_i,
    input logic           pwrite_i,
    input logic           first_strobe_i,
    input logic           second_strobe_i,
    input logic           alt_signal_i,
    input logic [31:0]    prdata_o,
    input logic           pready_o,
    input logic           pslverr_o,
    input logic           ch1_left_io_o,
    input logic           ch1_left_io_oe_o,
    input logic           ch1_right_io_oe_o,
    input logic           ch2_left_io_o,
    input logic           ch2_left_io_oe_o,
    input logic           ch2_right_io_oe_o,
    input logic [6*W-1:0] driver_outputs_o,
    input logic           snap_ready_o
);
    // pins pass a synchroniser, so outputs trail their cause by a few cycles
    logic [3:0] s_cnt_r;
    logic [3:0] a_cnt_r;
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_cnt_r <= 4'h0;
            a_cnt_r <= 4'h0;
        end
        else
        begin
            if ($changed(first_strobe_i) || $changed(second_strobe_i) || (psel_i && pwrite_i))
                s_cnt_r <= 4'h0;
            else if (s_cnt_r != 4'hf)
                s_cnt_r <= s_cnt_r + 4'h1;
            if ($changed(alt_signal_i))
                a_cnt_r <= 4'h0;
            else if (a_cnt_r != 4'hf)
                a_cnt_r <= a_cnt_r + 4'h1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    property p_no_wait; s_setup ##1 s_access |-> pready_o; endproperty
    a_no_wait: assert property (p_no_wait) else $error("no ready in access cycle");
    property p_ready_cause; pready_o |-> $past(psel_i) && !$past(penable_i); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
    property p_err_ready; pslverr_o |-> pready_o; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_rdata_idle; !pready_o |-> prdata_o == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
    property p_oe1; $past(resetn_i) |-> ch1_left_io_oe_o != ch1_right_io_oe_o; endproperty
    a_oe1: assert property (p_oe1) else $error("ch1 pin roles clash");
    property p_oe2; $past(resetn_i) |-> ch2_left_io_oe_o != ch2_right_io_oe_o; endproperty
    a_oe2: assert property (p_oe2) else $error("ch2 pin roles clash");
    property p_drv_quiet;
        $changed(driver_outputs_o) |-> s_cnt_r <= 4'h8 || a_cnt_r <= 4'h8;
    endproperty
    a_drv_quiet: assert property (p_drv_quiet) else $error("levels moved unprompted");
    property p_io_quiet;
        $changed(ch1_left_io_o) || $changed(ch2_left_io_o) |-> s_cnt_r <= 4'h8;
    endproperty
    a_io_quiet: assert property (p_io_quiet) else $error("shift out moved unprompted");
    property p_snap; $fell(snap_ready_o) |-> s_cnt_r <= 4'h9; endproperty
    a_snap: assert property (p_snap) else $error("snapshot full without latch");
endmodule // lsd_checker

bind lsd_top lsd_checker #(.W(W)) u_chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .first_strobe_i(first_strobe_i), .second_strobe_i(second_strobe_i),
    .alt_signal_i(alt_signal_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ch1_left_io_o(ch1_left_io_o), .ch1_left_io_oe_o(ch1_left_io_oe_o),
    .ch1_right_io_oe_o(ch1_right_io_oe_o), .ch2_left_io_o(ch2_left_io_o),
    .ch2_left_io_oe_o(ch2_left_io_oe_o), .ch2_right_io_oe_o(ch2_right_io_oe_o),
    .driver_outputs_o(driver_outputs_o), .snap_ready_o(snap_ready_o)
);

// File: dv/lsd_ctl_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// display controller
// ----------------------------------------
module lsd_ctl_model (
    input  logic clock_i,
    output logic first_strobe_o,
    output logic second_strobe_o,
    output logic alt_o,
    output logic ch1_left_o,
    output logic ch1_right_o,
    output logic ch2_left_o,
    output logic ch2_right_o
);
    initial
    begin
        {first_strobe_o, second_strobe_o, alt_o} = 3'h0;
        {ch1_left_o, ch1_right_o, ch2_left_o, ch2_right_o} = 4'h5;
    end
    task pulse(input logic sel, input logic d1, input logic d2, input logic r1, input logic r2);
        begin
            @(posedge clock_i);
            {ch1_right_o, ch1_left_o} <= r1 ? {d1, ~d1} : {~d1, d1};
            {ch2_right_o, ch2_left_o} <= r2 ? {d2, ~d2} : {~d2, d2};
            repeat (4) @(posedge clock_i);
            if (sel)
                second_strobe_o <= 1'b1;
            else
                first_strobe_o <= 1'b1;
            repeat (4) @(posedge clock_i);
            {first_strobe_o, second_strobe_o} <= 2'h0;
            repeat (4) @(posedge clock_i);
            // hold over: stale bits must not pass for data
            {ch1_left_o, ch1_right_o} <= ~{ch1_left_o, ch1_right_o};
            {ch2_left_o, ch2_right_o} <= ~{ch2_left_o, ch2_right_o};
        end
    endtask
    task set_alt(input logic v);
        alt_o <= v;
    endtask
endmodule // lsd_ctl_model

// File: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic         clock_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0]   paddr_i;
    logic [31:0]  pwdata_i, prdata_o, rdat;
    logic         rerr, snap_ready_o, alt_m;
    wire          fs, ss, alt;
    wire  [3:0]   p_pin, d_out, d_oe, pin;
    wire  [119:0] drv;
    logic [19:0]  sr1, sr2, la1, la2;
    logic [39:0]  snap_q[$];
    logic [2:0]   ctrl;
    int           n_errors, check_count;
    // pin order 3..0: ch1 left, ch1 right, ch2 left, ch2 right
    assign pin = (d_oe & d_out) | (~d_oe & p_pin);
    lsd_top uut (
        .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .first_strobe_i(fs),
        .second_strobe_i(ss), .alt_signal_i(alt),
        .ch1_left_io_i(pin[3]), .ch1_left_io_o(d_out[3]), .ch1_left_io_oe_o(d_oe[3]),
        .ch1_right_io_i(pin[2]), .ch1_right_io_o(d_out[2]), .ch1_right_io_oe_o(d_oe[2]),
        .ch2_left_io_i(pin[1]), .ch2_left_io_o(d_out[1]), .ch2_left_io_oe_o(d_oe[1]),
        .ch2_right_io_i(pin[0]), .ch2_right_io_o(d_out[0]), .ch2_right_io_oe_o(d_oe[0]),
        .driver_outputs_o(drv), .snap_ready_o(snap_ready_o)
    );
    lsd_ctl_model u_ctl (
        .clock_i(clock_i), .first_strobe_o(fs), .second_strobe_o(ss), .alt_o(alt),
        .ch1_left_o(p_pin[3]),
        .ch1_right_o(p_pin[2]), .ch2_left_o(p_pin[1]), .ch2_right_o(p_pin[0])
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task tally_and_finish;
        begin
            $display("errors %0d checks %0d", n_errors, check_count);
            if (n_errors == 0 && check_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [119:0] seen, input logic [119:0] expv);
        begin
            check_count++;
            if (seen !== expv)
            begin
                n_errors++;
                $display("wrong value %s expected %h seen %h", nm, expv, seen);
            end
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        begin
            n = 0;
            @(posedge clock_i);
            {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, wd};
            @(posedge clock_i);
            penable_i <= 1'b1;
            @(posedge clock_i);
            while (pready_o !== 1'b1 && n < 20)
            begin
                n++;
                @(posedge clock_i);
            end
            {rerr, rdat} = {pslverr_o, prdata_o};
            {psel_i, penable_i} <= 2'h0;
            if (n == 20)
            begin
                n_errors++;
                tally_and_finish();
            end
        end
    endtask
    function automatic logic [19:0] sh(input logic [19:0] r, input logic dir, input logic d);
        return dir ? {d, r[19:1]} : {r[18:0], d};
    endfunction
    function automatic logic [119:0] exp_lvl(input logic m);
        logic [119:0] e;
        logic         a2;
        begin
            a2 = m ^ ctrl[2];
            for (int k = 0; k < 20; k++)
            begin
                e[3*k +: 3] = la1[k] ? (m ? 3'h0 : 3'h1) : (m ? 3'h2 : 3'h3);
                e[60+3*k +: 3] = la2[k] ? (a2 ? 3'h0 : 3'h1) : (a2 ? 3'h4 : 3'h5);
            end
            return e;
        end
    endfunction
    // one strobe pulse; the expected state follows the edge rules per mode
    task pulse(input logic sel, input logic d1, input logic d2);
        begin
            u_ctl.pulse(sel, d1, d2, ctrl[0], ctrl[1]);
            if (sel)
            begin
                sr1 = sh(sr1, ctrl[0], d1);
                if (ctrl[2])
                    la2 = sr2;
                else
                    sr2 = sh(sr2, ctrl[1], d2);
            end
            else
            begin
                la1 = sr1;
                if (ctrl[2])
                    sr2 = sh(sr2, ctrl[1], d2);
                else
                    la2 = sr2;
                if (snap_q.size() < 8)
                    snap_q.push_back({la2, la1});
            end
            repeat (4) @(posedge clock_i);
        end
    endtask
    task chk_lvl(input logic m);
        begin
            alt_m = m;
            u_ctl.set_alt(m);
            repeat (8) @(posedge clock_i);
            chk("levels", drv, exp_lvl(m));
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        begin
            apb(0, 8'h00, 0);
            chk("ctrl reset", rdat, 0);
            apb(1, 8'h00, 32'h7);
            apb(0, 8'h00, 0);
            chk("ctrl rw", rdat, 32'h7);
            chk("oe high", d_oe, 4'b1010);
            apb(0, 8'h20, 0);
            chk("unmapped", {rerr, rdat}, {1'b1, 32'h0});
            apb(1, 8'h00, 0);
            repeat (2) @(posedge clock_i);
            chk("oe low", d_oe, 4'b0101);
        end
    endtask
    task t_seg;
        logic [19:0] v1, v2;
        begin
            for (int d = 0; d < 4; d++)
            begin
                ctrl = d[2:0];
                apb(1, 8'h00, {29'h0, ctrl});
                v1 = 20'h80001 << d;
                v2 = 20'hf00f3 >> d;
                for (int i = 0; i < 20; i++)
                    pulse(1, v1[ctrl[0] ? i : 19-i], v2[ctrl[1] ? i : 19-i]);
                chk("held while shifting", drv, exp_lvl(alt_m));
                chk("shift out", d_out, {{2{sr1[ctrl[0] ? 0 : 19]}},
                    {2{sr2[ctrl[1] ? 0 : 19]}}});
                pulse(0, 1'b0, 1'b0);
                apb(0, 8'h08, 0);
                chk("ch1 latch", rdat, {12'h0, v1});
                apb(0, 8'h0c, 0);
                chk("ch2 latch", rdat, {12'h0, v2});
                chk_lvl(1'b1);
                chk_lvl(1'b0);
            end
        end
    endtask
    task t_common;
        begin
            ctrl = 3'h6;
            apb(1, 8'h00, 32'h6);
            for (int i = 0; i < 20; i++)
            begin
                pulse(0, 1'b0, i[0] ^ i[2]);
                pulse(1, i[1], 1'b0);
            end
            apb(0, 8'h0c, 0);
            chk("common ch2 latch", rdat, {12'h0, la2});
            apb(0, 8'h08, 0);
            chk("common ch1 latch", rdat, {12'h0, la1});
            chk_lvl(1'b1);
            chk_lvl(1'b0);
        end
    endtask
    task t_fifo;
        logic [39:0] e;
        begin
            apb(0, 8'h04, 0);
            chk("stat full", rdat, 32'h86);
            chk("snap ready full", snap_ready_o, 0);
            while (snap_q.size() > 0)
            begin
                e = snap_q.pop_front();
                apb(0, 8'h10, 0);
                chk("snap ch1", rdat, {12'h0, e[19:0]});
                apb(0, 8'h14, 0);
                chk("snap ch2", rdat, {12'h0, e[39:20]});
            end
            apb(1, 8'h04, 32'h4);
            apb(0, 8'h04, 0);
            chk("stat empty", rdat, 32'h1);
            chk("snap ready", snap_ready_o, 1);
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial
    begin
        {resetn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 0;
        {n_errors, check_count, sr1, sr2, la1, la2, ctrl, alt_m} = 0;
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_regs;
        t_seg;
        t_common;
        t_fifo;
        tally_and_finish();
    end
endmodule // tb_top

// File: hw/lsd_chan.v
`timescale 1ns/1ns
`include "lsd_regs.vh"
module lsd_chan #(
    parameter       W      = 20,
    parameter [2:0] NSEL_H = `LSD_LVL_C,
    parameter [2:0] NSEL_L = `LSD_LVL_D
) (
    input  wire           clock_i,
    input  wire           resetn_i,
    input  wire           shift_ev_i,
    input  wire           latch_ev_i,
    input  wire           dir_i,
    input  wire           left_in_i,
    input  wire           right_in_i,
    input  wire           alt_i,
    output wire           shift_out_o,
    output wire [W-1:0]   latch_o,
    output reg  [3*W-1:0] levels_o
);
    reg [W-1:0] sr_r;
    reg [W-1:0] lat_r;
    integer     k;

    // one output's level from its latched bit and alternation
    function [2:0] lvl;
        input b;
        input m;
        begin
            if (b)
                lvl = m ? `LSD_LVL_A : `LSD_LVL_B;
            else
                lvl = m ? NSEL_H : NSEL_L;
        end
    endfunction

    // ----------------------------------------
    // shift register and latch
    // ----------------------------------------
    // bit 0 sits at the left end, bit W-1 at the right end
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sr_r  <= {W{1'b0}};
            lat_r <= {W{1'b0}};
        end
        else
        begin
            if (shift_ev_i)
            begin
                if (dir_i)
                    sr_r <= {right_in_i, sr_r[W-1:1]};
                else
                    sr_r <= {sr_r[W-2:0], left_in_i};
            end
            if (latch_ev_i)
                lat_r <= sr_r;
        end
    end

    assign shift_out_o = dir_i ? sr_r[0] : sr_r[W-1];
    assign latch_o     = lat_r;

    // ----------------------------------------
    // level selection
    // ----------------------------------------
    always @*
    begin
        levels_o = {3*W{1'b0}};
        for (k = 0; k < W; k = k + 1)
            levels_o[3*k +: 3] = lvl(lat_r[k], alt_i);
    end
endmodule // lsd_chan

// File: hw/lsd_fifo.v
`timescale 1ns/1ns
module lsd_fifo #(
    parameter W  = 40,
    parameter D  = 8,
    parameter AW = 3
) (
    input  wire          clock_i,
    input  wire          resetn_i,
    input  wire          in_valid_i,
    output wire          in_ready_o,
    input  wire [W-1:0]  in_data_i,
    output wire          out_valid_o,
    input  wire          out_ready_i,
    output wire [W-1:0]  out_data_o,
    output wire [AW:0]   count_o
);
    reg [W-1:0]  mem_r [0:D-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0]   cnt_r;
    wire         push;
    wire         pop;
    integer      i;

    // ----------------------------------------
    // flags
    // ----------------------------------------
    assign in_ready_o  = (cnt_r != D[AW:0]);
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o  = mem_r[rd_r];
    assign count_o     = cnt_r;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // pointers wrap explicitly so depth need not be a power of two
    function [AW-1:0] inc;
        input [AW-1:0] p;
        begin
            inc = (p == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
        end
    endfunction

    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            for (i = 0; i < D; i = i + 1)
                mem_r[i] <= {W{1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem_r[wr_r] <= in_data_i;
                wr_r        <= inc(wr_r);
            end
            if (pop)
                rd_r <= inc(rd_r);
            if (push & ~pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // lsd_fifo

// File: hw/lsd_top.v
`timescale 1ns/1ns
`include "lsd_regs.vh"
module lsd_top #(
    parameter W    = 20,
    parameter FD   = 8,
    parameter FAW  = 3
) (
    input  wire           clock_i,
    input  wire           resetn_i,
    input  wire           psel_i,
    input  wire           penable_i,
    input  wire           pwrite_i,
    input  wire [7:0]     paddr_i,
    input  wire [31:0]    pwdata_i,
    output reg  [31:0]    prdata_o,
    output reg            pready_o,
    output reg            pslverr_o,
    input  wire           first_strobe_i,
    input  wire           second_strobe_i,
    input  wire           alt_signal_i,
    input  wire           ch1_left_io_i,
    output reg            ch1_left_io_o,
    output reg            ch1_left_io_oe_o,
    input  wire           ch1_right_io_i,
    output reg            ch1_right_io_o,
    output reg            ch1_right_io_oe_o,
    input  wire           ch2_left_io_i,
    output reg            ch2_left_io_o,
    output reg            ch2_left_io_oe_o,
    input  wire           ch2_right_io_i,
    output reg            ch2_right_io_o,
    output reg            ch2_right_io_oe_o,
    output reg  [6*W-1:0] driver_outputs_o,
    output reg            snap_ready_o
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // order: first, second, alt, l1, r1, l2, r2
    wire [6:0] raw_w;
    reg  [6:0] sy1_r;
    reg  [6:0] sy2_r;
    reg        fs_prev_r;
    reg        ss_prev_r;

    assign raw_w = {first_strobe_i, second_strobe_i, alt_signal_i,
                    ch1_left_io_i, ch1_right_io_i,
                    ch2_left_io_i, ch2_right_io_i};

    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sy1_r     <= 7'h00;
            sy2_r     <= 7'h00;
            fs_prev_r <= 1'b0;
            ss_prev_r <= 1'b0;
        end
        else
        begin
            sy1_r     <= raw_w;
            sy2_r     <= sy1_r;
            fs_prev_r <= sy2_r[6];
            ss_prev_r <= sy2_r[5];
        end
    end

    // data passes the same two stages as the strobes, so the bit
    // seen at a strobe edge is the one the controller set up
    wire fs_w   = sy2_r[6];
    wire ss_w   = sy2_r[5];
    wire alt_w  = sy2_r[4];
    wire l1_w   = sy2_r[3];
    wire r1_w   = sy2_r[2];
    wire l2_w   = sy2_r[1];
    wire r2_w   = sy2_r[0];

    // one edge of a synchronised pin against its last sample
    function edg;
        input now;
        input was;
        input rise;
        begin
            edg = rise ? (now & ~was) : (~now & was);
        end
    endfunction

    wire fs_rise = edg(fs_w, fs_prev_r, 1'b1);
    wire fs_fall = edg(fs_w, fs_prev_r, 1'b0);
    wire ss_rise = edg(ss_w, ss_prev_r, 1'b1);
    wire ss_fall = edg(ss_w, ss_prev_r, 1'b0);

    // ----------------------------------------
    // control register
    // ----------------------------------------
    reg  [2:0] ctrl_r;
    wire       dir1_w = ctrl_r[`LSD_CTRL_DIR1_BIT];
    wire       dir2_w = ctrl_r[`LSD_CTRL_DIR2_BIT];
    wire       fsel_w = ctrl_r[`LSD_CTRL_FSEL_BIT];

    // ----------------------------------------
    // strobe routing
    // ----------------------------------------
    // channel 1 segment edges
    wire sh1_ev = ss_fall;
    wire la1_ev = fs_fall;
    // channel 2 strobes swap in common mode
    wire sh2_ev = fsel_w ? fs_rise : ss_fall;
    wire la2_ev = fsel_w ? ss_rise : fs_fall;
    // inverted alternation for common channel 2
    wire alt2_w = fsel_w ? ~alt_w : alt_w;

    // ----------------------------------------
    // channels
    // ----------------------------------------
    wire [W-1:0]   lat1_w;
    wire [W-1:0]   lat2_w;
    wire [3*W-1:0] lv1_w;
    wire [3*W-1:0] lv2_w;
    wire           so1_w;
    wire           so2_w;

    // channel 1 drives outputs 1 to 20
    lsd_chan #(
        .W      (W),
        .NSEL_H (`LSD_LVL_C),
        .NSEL_L (`LSD_LVL_D)
    ) u_ch1 (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .shift_ev_i  (sh1_ev),
        .latch_ev_i  (la1_ev),
        .dir_i       (dir1_w),
        .left_in_i   (l1_w),
        .right_in_i  (r1_w),
        .alt_i       (alt_w),
        .shift_out_o (so1_w),
        .latch_o     (lat1_w),
        .levels_o    (lv1_w)
    );

    // inverted alternation yields the common table
    lsd_chan #(
        .W      (W),
        .NSEL_H (`LSD_LVL_E),
        .NSEL_L (`LSD_LVL_F)
    ) u_ch2 (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .shift_ev_i  (sh2_ev),
        .latch_ev_i  (la2_ev),
        .dir_i       (dir2_w),
        .left_in_i   (l2_w),
        .right_in_i  (r2_w),
        .alt_i       (alt2_w),
        .shift_out_o (so2_w),
        .latch_o     (lat2_w),
        .levels_o    (lv2_w)
    );

    // ----------------------------------------
    // pins and driver outputs
    // ----------------------------------------
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ch1_left_io_o     <= 1'b0;
            ch1_left_io_oe_o  <= 1'b0;
            ch1_right_io_o    <= 1'b0;
            ch1_right_io_oe_o <= 1'b0;
            ch2_left_io_o     <= 1'b0;
            ch2_left_io_oe_o  <= 1'b0;
            ch2_right_io_o    <= 1'b0;
            ch2_right_io_oe_o <= 1'b0;
            driver_outputs_o  <= {6*W{1'b0}};
        end
        else
        begin
            // channel 1 output pin by direction
            ch1_left_io_o     <= so1_w;
            ch1_left_io_oe_o  <= dir1_w;
            ch1_right_io_o    <= so1_w;
            ch1_right_io_oe_o <= ~dir1_w;
            // channel 2 output pin by direction
            ch2_left_io_o     <= so2_w;
            ch2_left_io_oe_o  <= dir2_w;
            ch2_right_io_o    <= so2_w;
            ch2_right_io_oe_o <= ~dir2_w;
            driver_outputs_o  <= {lv2_w, lv1_w};
        end
    end

    // ----------------------------------------
    // latch snapshot fifo
    // ----------------------------------------
    // each channel 1 latch load queues both latches for software unless the fifo is full;
    // the push waits one cycle so the new latch contents are seen
    reg          snap_req_r;
    wire         f_in_rdy;
    wire         f_out_vld;
    wire [2*W-1:0] f_out_dat;
    wire [FAW:0] f_cnt;
    wire         snap_pop;
    reg          ovf_r;

    lsd_fifo #(
        .W  (2*W),
        .D  (FD),
        .AW (FAW)
    ) u_fifo (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (snap_req_r),
        .in_ready_o  (f_in_rdy),
        .in_data_i   ({lat2_w, lat1_w}),
        .out_valid_o (f_out_vld),
        .out_ready_i (snap_pop),
        .out_data_o  (f_out_dat),
        .count_o     (f_cnt)
    );

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // answer is registered in setup; access always ends in one cycle
    wire setup_w  = psel_i & ~penable_i;
    wire done_w   = psel_i & penable_i & pready_o;
    wire wr_done  = done_w & pwrite_i;
    wire rd_done  = done_w & ~pwrite_i;

    // exact byte match; any other address is refused
    function hit;
        input [7:0] a;
        input [7:0] o;
        begin
            hit = (a == o);
        end
    endfunction

    wire stat_clr = wr_done & hit(paddr_i, `LSD_STAT_OFS)
                    & pwdata_i[`LSD_STAT_OVF_BIT];

    assign snap_pop = rd_done & hit(paddr_i, `LSD_SNAP_HI_OFS);

    reg [31:0] rd_nxt;
    reg        err_nxt;

    always @*
    begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        if (hit(paddr_i, `LSD_CTRL_OFS))
            rd_nxt[2:0] = ctrl_r;
        else if (hit(paddr_i, `LSD_STAT_OFS))
        begin
            rd_nxt[`LSD_STAT_EMPTY_BIT] = ~f_out_vld;
            rd_nxt[`LSD_STAT_FULL_BIT]  = ~f_in_rdy;
            rd_nxt[`LSD_STAT_OVF_BIT]   = ovf_r;
            rd_nxt[`LSD_STAT_CNT_LSB +: FAW+1] = f_cnt;
        end
        else if (hit(paddr_i, `LSD_LATCH1_OFS))
            rd_nxt[W-1:0] = lat1_w;
        else if (hit(paddr_i, `LSD_LATCH2_OFS))
            rd_nxt[W-1:0] = lat2_w;
        else if (hit(paddr_i, `LSD_SNAP_LO_OFS))
            rd_nxt[W-1:0] = f_out_dat[W-1:0];
        else if (hit(paddr_i, `LSD_SNAP_HI_OFS))
            rd_nxt[W-1:0] = f_out_dat[2*W-1:W];
        else
            err_nxt = 1'b1;
        if (pwrite_i)
            rd_nxt = 32'h0000_0000;
    end

    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_r       <= `LSD_CTRL_RST;
            prdata_o     <= 32'h0000_0000;
            pready_o     <= 1'b0;
            pslverr_o    <= 1'b0;
            snap_req_r   <= 1'b0;
            snap_ready_o <= 1'b0;
            ovf_r        <= 1'b0;
        end
        else
        begin
            pready_o  <= setup_w;
            pslverr_o <= setup_w & err_nxt;
            prdata_o  <= setup_w ? rd_nxt : 32'h0000_0000;
            if (wr_done & hit(paddr_i, `LSD_CTRL_OFS))
                ctrl_r <= pwdata_i[2:0];
            snap_req_r   <= la1_ev;
            snap_ready_o <= f_in_rdy;
            // lost snapshot sets the flag; set beats a clear
            if (snap_req_r & ~f_in_rdy)
                ovf_r <= 1'b1;
            else if (stat_clr)
                ovf_r <= 1'b0;
        end
    end
endmodule // lsd_top
